// file: dv/adc_conversion_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "adcseq_map.svh"
module adc_conversion_sequencer_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        pce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, irq, comp_hi, an_sel_valid, sample_en, ladder_on, trg;
	logic [9:0]  dac_code;
	logic [2:0]  an_sel;
	logic [31:0] em;
	int          n_fail = 0;
	int          tests_run = 0;
	int          n, lim;

	// 100 MHz clock
	always #5 pclk = ~pclk;

	adcseq_top DUT (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .comp_hi(comp_hi), .dac_code(dac_code), .an_sel(an_sel),
		.an_sel_valid(an_sel_valid), .sample_en(sample_en), .ladder_on(ladder_on),
		.external_trigger_pin(trg), .irq(irq));

	adcseq_afe_model afe (.pclk(pclk), .dac_code(dac_code), .an_sel(an_sel), .an_sel_valid(an_sel_valid),
		.sample_en(sample_en), .comp_hi(comp_hi), .trig_pin(trg));

	// level that the front end presents on channel index ch
	function automatic logic [9:0] lvl(input int ch);
		return 10'h0A5 + 10'(ch) * 10'h051;
	endfunction

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer: setup, then access held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the answer; only the watchdog ends a hang
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	// let the registered interrupt settle, then compare it
	task automatic irq_is(input logic v);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, {31'h0, v});
	endtask

	// poll the start flag until the converter is back in wait
	task automatic wait_idle;
		do
			apb(1'b0, `ADCSEQ_OFF_START, 32'h0000_0000);
		while (rd[7] !== 1'b0);
	endtask

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// cut a hang short
	initial
	begin
		#200us;
		n_fail++;
		report_and_stop();
	end

	// main sequence
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(`ADCSEQ_OFF_MODE, 32'h0000_0000);
		rdchk(`ADCSEQ_OFF_START, 32'h0000_003F);
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		apb(1'b1, `ADCSEQ_OFF_IRQ_EN, 32'h0000_0001);
		// software start on every valid channel code, 0100 to 1011
		for (int c = 4; c < 12; c++)
		begin
			apb(1'b1, `ADCSEQ_OFF_MODE, 32'h0000_0020 | c);
			apb(1'b1, `ADCSEQ_OFF_START, 32'h0000_0080);
			rdchk(`ADCSEQ_OFF_START, 32'h0000_00BF);
			chk({29'h0, an_sel}, c - 4);
			wait_idle();
			irq_is(1'b1);
			rdchk(`ADCSEQ_OFF_IRQ_STAT, 32'h0000_0001);
			rdchk(`ADCSEQ_OFF_RESULT, {16'h0, lvl(c - 4), 6'h0});
			apb(1'b1, `ADCSEQ_OFF_IRQ_STAT, 32'h0000_0001);
			irq_is(1'b0);
		end
		// conversion time for clock select codes 0 to 2
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b1, `ADCSEQ_OFF_MODE, 32'h0000_0004 | (k << 4));
			apb(1'b1, `ADCSEQ_OFF_START, 32'h0000_0080);
			lim = (124 >> k) + 2;
			n = 0;
			while (irq !== 1'b1 && n < 400)
			begin
				@(posedge pclk);
				n++;
			end
			chk((n > lim) ? n : lim, lim);
			wait_idle();
			apb(1'b1, `ADCSEQ_OFF_IRQ_STAT, 32'h0000_0001);
		end
		// forced stop in mid-conversion
		apb(1'b1, `ADCSEQ_OFF_START, 32'h0000_0080);
		repeat (5) @(posedge pclk);
		apb(1'b1, `ADCSEQ_OFF_START, 32'h0000_0000);
		repeat (300) @(posedge pclk);
		rdchk(`ADCSEQ_OFF_START, 32'h0000_003F);
		rdchk(`ADCSEQ_OFF_IRQ_STAT, 32'h0000_0000);
		irq_is(1'b0);
		// trigger qualifiers and edge polarity, interrupt masked
		apb(1'b1, `ADCSEQ_OFF_IRQ_EN, 32'h0000_0000);
		for (int j = 0; j < 4; j++)
		begin
			apb(1'b1, `ADCSEQ_OFF_PORT_MODE, {31'h0, j != 1});
			apb(1'b1, `ADCSEQ_OFF_MODE, {25'h0, j != 0, 6'h24});
			apb(1'b1, `ADCSEQ_OFF_EDGE_SEL, {31'h0, j == 3});
			afe.pulse();
			rdchk(`ADCSEQ_OFF_START, (j >= 2) ? 32'h0000_00BF : 32'h0000_003F);
			wait_idle();
			irq_is(1'b0);
			rdchk(`ADCSEQ_OFF_IRQ_STAT, {31'h0, j >= 2});
			apb(1'b1, `ADCSEQ_OFF_IRQ_STAT, 32'h0000_0001);
		end
		// mode register works only in active and sleep
		em = 32'h0000_0064;
		for (int m = 0; m < 7; m++)
		begin
			apb(1'b1, `ADCSEQ_OFF_PWR_MODE, m);
			apb(1'b1, `ADCSEQ_OFF_MODE, 32'h0000_0020 | (m + 4));
			if (m < 2)
				em = 32'h0000_0020 | (m + 4);
			rdchk(`ADCSEQ_OFF_MODE, em);
		end
		// leave module standby, wait ten clocks, then convert
		apb(1'b1, `ADCSEQ_OFF_PWR_MODE, 32'h0000_0000);
		repeat (10) @(posedge pclk);
		apb(1'b1, `ADCSEQ_OFF_START, 32'h0000_0080);
		// clock enable low for longer than a conversion: the engine must freeze
		pce <= 1'b0;
		repeat (50) @(posedge pclk);
		pce <= 1'b1;
		rdchk(`ADCSEQ_OFF_START, 32'h0000_00BF);
		wait_idle();
		rdchk(`ADCSEQ_OFF_RESULT, {16'h0, lvl(1), 6'h0});
		chk({31'h0, ladder_on}, 32'h0000_0001);
		// ladder bit set while idle turns the ladder off
		apb(1'b1, `ADCSEQ_OFF_START, 32'h0000_0040);
		rdchk(`ADCSEQ_OFF_START, 32'h0000_007F);
		chk({31'h0, ladder_on}, 32'h0000_0000);
		// ordinary reset keeps the result, clears mode and start
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(`ADCSEQ_OFF_RESULT, {16'h0, lvl(1), 6'h0});
		rdchk(`ADCSEQ_OFF_MODE, 32'h0000_0000);
		rdchk(`ADCSEQ_OFF_START, 32'h0000_003F);
		report_and_stop();
	end
endmodule

// file: dv/adcseq_afe_model.sv
// analog front end and trigger source that face the sequencer
`timescale 1ns/1ps
module adcseq_afe_model
(
	// clock
	input  wire logic       pclk,
	// analog side
	input  wire logic [9:0] dac_code,
	input  wire logic [2:0] an_sel,
	input  wire logic       an_sel_valid,
	input  wire logic       sample_en,
	output logic            comp_hi,
	// trigger pin
	output logic            trig_pin
);
	logic [9:0] held_ff = 10'h000;
	// hold the channel level while sampling; no channel reads as ground
	always @(posedge pclk)
	begin
		if (sample_en)
			held_ff <= an_sel_valid ? 10'h0A5 + 10'h051 * 10'(an_sel) : 10'h000;
	end
	// comparator: high while the held level is at or above the trial code
	assign comp_hi = held_ff >= dac_code;
	// pin fixed low from time zero, so reset is released on a steady level
	initial trig_pin = 1'b0;
	// one high pulse: a rising edge, then a falling edge three cycles later
	task automatic pulse;
		@(posedge pclk);
		trig_pin <= 1'b1;
		repeat (3) @(posedge pclk);
		trig_pin <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
endmodule

// file: logic/adcseq_edge_det.sv
// trigger pin edge detector with selectable polarity
`timescale 1ns/1ps
module adcseq_edge_det
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// pin and control
	input  wire logic pin_in,
	input  wire logic fall_sel,
	input  wire logic arm,
	// detected edge
	output logic      edge_pulse
);
	import adcseq_pkg::*;
	logic pin_ff;
	logic nxt_pin;

	// previous pin sample
	assign nxt_pin = pin_in;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_ff <= 1'b0;
		else if (ce)
			pin_ff <= nxt_pin;
	end

	// edge of the chosen polarity, only while armed
	assign edge_pulse = ce && arm && (fall_sel ? (pin_ff && !pin_in) : (!pin_ff && pin_in));
endmodule

// file: logic/adcseq_map.svh
// register offsets, field positions, reset values and timing counts of the conversion sequencer
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH
`define ADCSEQ_OFF_RESULT     12'h000
`define ADCSEQ_OFF_MODE       12'h004
`define ADCSEQ_OFF_START      12'h008
`define ADCSEQ_OFF_IRQ_STAT   12'h00C
`define ADCSEQ_OFF_IRQ_EN     12'h010
`define ADCSEQ_OFF_PORT_MODE  12'h014
`define ADCSEQ_OFF_EDGE_SEL   12'h018
`define ADCSEQ_OFF_PWR_MODE   12'h01C
`define ADCSEQ_MODE_CH_LSB    0
`define ADCSEQ_MODE_CKS_LSB   4
`define ADCSEQ_MODE_EXTERNAL_TRIGGER_ENABLE_BIT  6
`define ADCSEQ_START_FLAG_BIT 7
`define ADCSEQ_START_LADS_BIT 6
`define ADCSEQ_START_RSVD     8'h3F
`define ADCSEQ_MODE_RESET     8'h00
`define ADCSEQ_START_RESET    8'h3F
`define ADCSEQ_RESULT_LSB     6
`define ADCSEQ_STATES_DIV8    8'd124
`define ADCSEQ_STATES_DIV4    8'd62
`define ADCSEQ_STATES_DIV2    8'd31
`define ADCSEQ_SAMPLE_CLKS    8'd5
`define ADCSEQ_RES_BITS       10
`endif

// file: logic/adcseq_pkg.sv
// types shared by the conversion sequencer files
package adcseq_pkg;
	typedef enum logic [1:0] {ADCSEQ_CK_DIV8, ADCSEQ_CK_DIV4, ADCSEQ_CK_DIV2, ADCSEQ_CK_BAD} adcseq_cks_t;
	typedef enum logic [2:0] {ADCSEQ_PM_ACTIVE, ADCSEQ_PM_SLEEP, ADCSEQ_PM_WATCH, ADCSEQ_PM_SUBACT,
		ADCSEQ_PM_SUBSLP, ADCSEQ_PM_STBY, ADCSEQ_PM_MSTBY} adcseq_pmode_t;
	typedef enum logic [1:0] {ADCSEQ_ST_WAIT, ADCSEQ_ST_SAMPLE, ADCSEQ_ST_APPROX} adcseq_state_t;
endpackage

// file: logic/adcseq_sar.sv
// ten-bit successive approximation core, one decision per conversion clock
`timescale 1ns/1ps
`include "adcseq_map.svh"
module adcseq_sar
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	// control
	input  wire logic       clr,
	input  wire logic       step,
	input  wire logic       load,
	input  wire logic       comp_hi,
	// approximation
	output logic [9:0]      trial,
	output logic            last
);
	import adcseq_pkg::*;
	logic [9:0] code_ff;
	logic [9:0] bit_ff;
	logic [9:0] nxt_code;
	logic [9:0] nxt_bit;

	// keep or drop the trial bit, then move to the next lower weight
	always_comb
	begin
		nxt_code = code_ff;
		nxt_bit  = bit_ff;
		if (load)
		begin
			nxt_code = 10'h200;
			nxt_bit  = 10'h200;
		end
		else if (step)
		begin
			nxt_code = (comp_hi ? code_ff : (code_ff & ~bit_ff)) | (bit_ff >> 1);
			nxt_bit  = bit_ff >> 1;
		end
		else if (clr)
		begin
			nxt_code = 10'h000;
			nxt_bit  = 10'h000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			code_ff <= 10'h000;
			bit_ff  <= 10'h000;
		end
		else if (ce)
		begin
			code_ff <= nxt_code;
			bit_ff  <= nxt_bit;
		end
	end

	// trial code seen by the comparator, final step when weight is one
	assign trial = code_ff;
	assign last  = bit_ff[0];
endmodule

// file: logic/adcseq_top.sv
// conversion sequencer for a ten-bit successive approximation converter with APB registers
`timescale 1ns/1ps
`include "adcseq_map.svh"
module adcseq_top
(
	// clock, reset and enable
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  pce,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	// analog front end
	input  wire logic                  comp_hi,
	output logic [9:0]                 dac_code,
	output logic [2:0]                 an_sel,
	output logic                       an_sel_valid,
	output logic                       sample_en,
	output logic                       ladder_on,
	// trigger pin and interrupt
	input  wire logic                  external_trigger_pin,
	output logic                       irq
);
	import adcseq_pkg::*;
	// registers
	logic [7:0]      mode_ff;
	logic            conversion_start_flag_ff;
	logic            lads_ff;
	logic [15:0]     conversion_result_register_ff;
	logic            conversion_end_flag_ff;
	logic            conversion_end_irq_enable_ff;
	logic            trigger_pin_function_select_ff;
	logic            trigger_edge_select_ff;
	adcseq_pmode_t   pmode_ff;
	adcseq_state_t   state_ff;
	adcseq_state_t   nxt_state;
	logic [7:0]      div_ff;
	logic [7:0]      nxt_div;
	logic            pready_ff;
	logic [31:0]     prdata_ff;
	logic            pslverr_ff;
	logic            irq_ff;
	logic [9:0]      dac_ff;
	logic [2:0]      an_ff;
	logic            an_vld_ff;
	logic            samp_ff;

	// decode helpers
	logic            run_ce;
	logic            wr_acc;
	logic            ladder_ff;
	logic            hit;
	logic            wr_start;
	logic            start_req;
	logic            stop_req;
	logic            trig_edge;
	logic            tick;
	logic            done;
	logic            busy;
	logic [9:0]      trial;
	logic            last;
	logic [31:0]     nxt_prdata;

	// conversion clock period in system clocks per clock select code
	function automatic logic [7:0] conv_period(input logic [1:0] cks);
		case (cks)
			2'b00:   conv_period = 8'd8;
			2'b01:   conv_period = 8'd4;
			2'b10:   conv_period = 8'd2;
			default: conv_period = 8'd8;
		endcase
	endfunction

	// channel code to input index, valid for 0100 to 1011 only
	function automatic logic [3:0] chan_decode(input logic [3:0] ch);
		chan_decode = (ch >= 4'h4 && ch <= 4'hB) ? {1'b1, 3'(ch - 4'h4)} : 4'h0;
	endfunction

	// clocks and low power modes: only active and sleep let state move
	assign run_ce = pce && (pmode_ff == ADCSEQ_PM_ACTIVE || pmode_ff == ADCSEQ_PM_SLEEP);
	assign hit    = psel && !penable;
	assign wr_acc = psel && penable && pwrite && pready_ff;
	assign wr_start = wr_acc && paddr == `ADCSEQ_OFF_START && pstrb[0];
	assign start_req = (wr_start && pwdata[`ADCSEQ_START_FLAG_BIT]) || trig_edge;
	assign stop_req  = wr_start && !pwdata[`ADCSEQ_START_FLAG_BIT] && busy;
	assign busy      = state_ff != ADCSEQ_ST_WAIT;
	assign tick      = busy && div_ff == 8'd1;
	assign done      = state_ff == ADCSEQ_ST_APPROX && tick && last;

	// trigger edge detection, armed by both enables
	adcseq_edge_det u_edge
	(
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (run_ce),
		.pin_in     (external_trigger_pin),
		.fall_sel   (trigger_edge_select_ff),
		.arm        (trigger_pin_function_select_ff && mode_ff[`ADCSEQ_MODE_EXTERNAL_TRIGGER_ENABLE_BIT]),
		.edge_pulse (trig_edge)
	);

	// approximation register
	adcseq_sar u_sar
	(
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (run_ce),
		.clr     (stop_req),
		.step    (state_ff == ADCSEQ_ST_APPROX && tick),
		.load    (state_ff == ADCSEQ_ST_SAMPLE && tick),
		.comp_hi (comp_hi),
		.trial   (trial),
		.last    (last)
	);

	// sequencer: sample for five conversion clocks then ten decisions, inside the maximum conversion time
	always_comb
	begin
		nxt_state = state_ff;
		nxt_div   = div_ff;
		case (state_ff)
			ADCSEQ_ST_WAIT:
			begin
				if (start_req)
				begin
					nxt_state = ADCSEQ_ST_SAMPLE;
					nxt_div   = 8'(conv_period(mode_ff[5:4]) * `ADCSEQ_SAMPLE_CLKS);
				end
			end
			ADCSEQ_ST_SAMPLE:
			begin
				nxt_div = div_ff - 8'd1;
				if (tick)
				begin
					nxt_state = ADCSEQ_ST_APPROX;
					nxt_div   = conv_period(mode_ff[5:4]);
				end
			end
			ADCSEQ_ST_APPROX:
			begin
				nxt_div = tick ? conv_period(mode_ff[5:4]) : div_ff - 8'd1;
				if (done)
					nxt_state = ADCSEQ_ST_WAIT;
			end
			default:
				nxt_state = ADCSEQ_ST_WAIT;
		endcase
		if (stop_req)
		begin
			nxt_state = ADCSEQ_ST_WAIT;
			nxt_div   = 8'd0;
		end
	end

	// state and divider
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= ADCSEQ_ST_WAIT;
			div_ff   <= 8'd0;
		end
		else if (run_ce)
		begin
			state_ff <= nxt_state;
			div_ff   <= nxt_div;
		end
	end

	// start flag mirrors an active conversion
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			conversion_start_flag_ff <= 1'b0;
		else if (run_ce)
			conversion_start_flag_ff <= (nxt_state != ADCSEQ_ST_WAIT);
	end

	// result register has no reset so it survives ordinary reset
	always_ff @(posedge pclk)
	begin
		if (run_ce && done)
			conversion_result_register_ff <= {trial[9:1], comp_hi, 6'h00};
	end

	// mode, start ladder bit, enables and edge select writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_ff                        <= `ADCSEQ_MODE_RESET;
			lads_ff                        <= 1'b0;
			conversion_end_irq_enable_ff   <= 1'b0;
			trigger_pin_function_select_ff <= 1'b0;
			trigger_edge_select_ff         <= 1'b0;
		end
		else if (run_ce && wr_acc && pstrb[0])
		begin
			case (paddr)
				`ADCSEQ_OFF_MODE:      mode_ff <= {1'b0, pwdata[6:0]};
				`ADCSEQ_OFF_START:     lads_ff <= pwdata[`ADCSEQ_START_LADS_BIT];
				`ADCSEQ_OFF_IRQ_EN:    conversion_end_irq_enable_ff <= pwdata[0];
				`ADCSEQ_OFF_PORT_MODE: trigger_pin_function_select_ff <= pwdata[0];
				`ADCSEQ_OFF_EDGE_SEL:  trigger_edge_select_ff <= pwdata[0];
				default:               mode_ff <= mode_ff;
			endcase
		end
	end

	// power mode register stays writable in every mode so software can wake the block
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pmode_ff <= ADCSEQ_PM_ACTIVE;
		else if (pce && wr_acc && pstrb[0] && paddr == `ADCSEQ_OFF_PWR_MODE)
			pmode_ff <= (pwdata[2:0] > 3'd6) ? ADCSEQ_PM_ACTIVE : adcseq_pmode_t'(pwdata[2:0]);
	end

	// sticky end flag, write one clears, completion wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			conversion_end_flag_ff <= 1'b0;
		else if (run_ce)
		begin
			if (done)
				conversion_end_flag_ff <= 1'b1;
			else if (wr_acc && pstrb[0] && paddr == `ADCSEQ_OFF_IRQ_STAT && pwdata[0])
				conversion_end_flag_ff <= 1'b0;
		end
	end

	// interrupt line
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_ff <= 1'b0;
		else if (pce)
			irq_ff <= (conversion_end_flag_ff || (run_ce && done)) && conversion_end_irq_enable_ff;
	end

	// read mux
	always_comb
	begin
		case (paddr)
			`ADCSEQ_OFF_RESULT:    nxt_prdata = {16'h0000, conversion_result_register_ff};
			`ADCSEQ_OFF_MODE:      nxt_prdata = {24'h00_0000, mode_ff};
			`ADCSEQ_OFF_START:     nxt_prdata = {24'h00_0000, conversion_start_flag_ff, lads_ff, 6'h3F};
			`ADCSEQ_OFF_IRQ_STAT:  nxt_prdata = {31'h0000_0000, conversion_end_flag_ff};
			`ADCSEQ_OFF_IRQ_EN:    nxt_prdata = {31'h0000_0000, conversion_end_irq_enable_ff};
			`ADCSEQ_OFF_PORT_MODE: nxt_prdata = {31'h0000_0000, trigger_pin_function_select_ff};
			`ADCSEQ_OFF_EDGE_SEL:  nxt_prdata = {31'h0000_0000, trigger_edge_select_ff};
			`ADCSEQ_OFF_PWR_MODE:  nxt_prdata = {29'h0000_0000, pmode_ff};
			default:               nxt_prdata = 32'h0000_0000;
		endcase
	end

	// apb answer: ready one cycle after setup, error on unmapped offsets
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end
		else if (pce)
		begin
			pready_ff  <= hit;
			pslverr_ff <= hit && (paddr[1:0] != 2'b00 || paddr > `ADCSEQ_OFF_PWR_MODE);
			if (hit && !pwrite)
				prdata_ff <= nxt_prdata;
		end
	end

	// analog side controls
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dac_ff    <= 10'h000;
			an_ff     <= 3'd0;
			an_vld_ff <= 1'b0;
			samp_ff   <= 1'b0;
			ladder_ff <= 1'b0;
		end
		else if (run_ce)
		begin
			dac_ff    <= trial;
			{an_vld_ff, an_ff} <= chan_decode(mode_ff[3:0]);
			samp_ff   <= nxt_state == ADCSEQ_ST_SAMPLE;
			ladder_ff <= (chan_decode(mode_ff[3:0]) >= 4'h8) && !lads_ff; // ladder powered for a valid channel while the ladder bit is clear
		end
	end

	assign pready       = pready_ff;
	assign prdata       = prdata_ff;
	assign pslverr      = pslverr_ff;
	assign irq          = irq_ff;
	assign dac_code     = dac_ff;
	assign an_sel       = an_ff;
	assign an_sel_valid = an_vld_ff;
	assign sample_en    = samp_ff;
	assign ladder_on    = ladder_ff;
	// write of one to the start flag leaves it set on the next cycle
	a_start_sets: assert property (@(posedge pclk) disable iff (!presetn)
		(run_ce && !busy && wr_start && pwdata[7] && !stop_req) |=> conversion_start_flag_ff)
		else $error("start write did not set flag");
	// completion clears start flag and sets end flag together
	a_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
		(run_ce && done && !start_req) |=> (!conversion_start_flag_ff && conversion_end_flag_ff))
		else $error("completion did not clear start and set end flag");
	// flag follows the engine
	a_flag_busy: assert property (@(posedge pclk) disable iff (!presetn)
		conversion_start_flag_ff == busy)
		else $error("start flag disagrees with engine");
	// result stored at completion with six low zeros
	a_result_load: assert property (@(posedge pclk) disable iff (!presetn)
		(run_ce && done) |=> conversion_result_register_ff[15:6] == $past(trial[9:1]) * 2 + $past(comp_hi)
			&& conversion_result_register_ff[5:0] == 6'h00)
		else $error("result not loaded");
	// interrupt follows flag and enable
	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		(pce && conversion_end_flag_ff && conversion_end_irq_enable_ff) |=> irq)
		else $error("irq not raised");
	// interrupt low without enable
	a_irq_mask: assert property (@(posedge pclk) disable iff (!presetn)
		(pce && !conversion_end_irq_enable_ff) |=> !irq)
		else $error("irq raised while masked");
	// no trigger without both enables
	a_trig_gate: assert property (@(posedge pclk) disable iff (!presetn)
		trig_edge |-> (trigger_pin_function_select_ff && mode_ff[6]))
		else $error("trigger honoured while disabled");
	// abort ends conversion next cycle
	a_abort_stop: assert property (@(posedge pclk) disable iff (!presetn)
		(run_ce && stop_req) |=> !busy)
		else $error("abort did not stop conversion");
	// held modes freeze the engine
	a_hold_mode: assert property (@(posedge pclk) disable iff (!presetn)
		(!run_ce) |=> $stable(state_ff) && $stable(mode_ff))
		else $error("state moved in hold mode");
endmodule
